// File: cmd_param_pkg.sv
// Package with constants and types for the command parameter byte file
package cmd_param_pkg;

   localparam int NUM_BYTES       = 12;
   localparam int IDX_W           = 4;
   // Byte numbers of the fields
   localparam logic [3:0] IDX_OPCODE  = 4'h0;
   localparam logic [3:0] IDX_ADDR_HI = 4'h1;
   localparam logic [3:0] IDX_ADDR_MD = 4'h2;
   localparam logic [3:0] IDX_ADDR_LO = 4'h3;
   localparam logic [3:0] IDX_DATA0   = 4'h4;
   localparam logic [3:0] IDX_LAST    = 4'hB;
   localparam logic [7:0] BYTE_RESET  = 8'h00;

   // Access sizes
   typedef enum logic [1:0] {
      SIZE_BYTE = 2'b00,
      SIZE_HALF = 2'b01,
      SIZE_WORD = 2'b10
   } access_size_t;

   // One software access to the byte file
   typedef struct packed {
      logic         valid;
      logic         write;
      access_size_t size;
      logic [3:0]   index;
      logic [31:0]  wdata;
   } access_req_t;

   // Decoded command handed to the sequencer
   typedef struct packed {
      logic [7:0]  opcode;
      logic [23:0] address;
      logic [63:0] data;
   } command_t;

   // Controller write-back of one result byte
   typedef struct packed {
      logic       valid;
      logic [3:0] index;
      logic [7:0] value;
   } result_wr_t;

endpackage : cmd_param_pkg

// File: command_parameter_bytes.sv
// Twelve-byte command parameter file with launch and lock control
// Summary of operation
// - Byte zero holds the 8-bit flash operation code.
// - Bytes one to three hold address bits 23:16, 15:8, 7:0.
// - Bytes four to eleven hold data bytes zero to seven in order.
// - Multi-byte fields are big-endian: most significant at lowest byte.
// - Byte, aligned halfword and aligned word reads and writes are accepted.
// - Writing one to complete flag launches, clears flag, locks bytes.
// - No queueing; next command loads only after current one completes.
// - Result bytes written back are valid when complete flag returns.
// - Twelve byte registers, numbered 0 to 11, written in any order.
module command_parameter_bytes
   import cmd_param_pkg::*;
(
   input  wire logic        ref_clk,     // System clock, 50 MHz
   input  wire logic        resetn,      // Asynchronous reset, active low
   input  wire access_req_t req,         // Software access request
   input  wire logic        launchWr,    // Write of one to complete flag
   input  wire result_wr_t  resultWr,    // Controller result write-back
   input  wire logic        cmdDone,     // Controller finished the command
   output logic [31:0]      rdata_r,     // Read data, big-endian packed
   output logic             rvalid_r,    // Read data valid pulse
   output logic             reqErr_r,    // Refused access pulse
   output logic             command_complete_flag_r, // Idle when high
   output logic             cmdStart_r,  // One-cycle command launch pulse
   output command_t         cmd_r        // Command snapshot at launch
);

   logic [7:0] paramByte_r [NUM_BYTES];

   // Alignment and range check for a request
   function automatic logic accessOk(access_req_t a);
      logic [4:0] last;
      last = 5'd0;
      accessOk = 1'b0;
      case (a.size)
         SIZE_BYTE: begin
            last = {1'b0, a.index};
            accessOk = 1'b1;
         end
         SIZE_HALF: begin
            last = {1'b0, a.index} + 5'd1;
            accessOk = (a.index[0] == 1'b0);
         end
         SIZE_WORD: begin
            last = {1'b0, a.index} + 5'd3;
            accessOk = (a.index[1:0] == 2'b00);
         end
         default: accessOk = 1'b0;
      endcase
      if (last > {1'b0, IDX_LAST}) begin
         accessOk = 1'b0;
      end
   endfunction

   // Byte count of a size code
   function automatic logic [2:0] sizeBytes(access_size_t s);
      case (s)
         SIZE_HALF: sizeBytes = 3'd2;
         SIZE_WORD: sizeBytes = 3'd4;
         default:   sizeBytes = 3'd1;
      endcase
   endfunction

   // Bit offset of lane k; lane zero is the most significant used lane
   function automatic int laneBase(access_size_t s, int k);
      laneBase = 8 * (int'(sizeBytes(s)) - 1 - k);
   endfunction

   // Decode of the current request and of the controller side
   logic        reqOk;                      // Legal access this cycle
   logic        locked;                     // Command running
   logic        swWrite;                    // Accepted software write
   logic        swRead;                     // Accepted software read
   logic        resultOk;                   // Accepted result write-back
   logic        launchOk;                   // Launch taken this cycle
   logic [7:0]  paramByte_nxt [NUM_BYTES];  // Next byte values
   logic [31:0] rdata_nxt;                  // Next read data

   // Shared by the write and read paths
   assign reqOk = req.valid && accessOk(req);

   // Bytes frozen to software writes while a command runs; nothing is queued behind it
   assign locked = !command_complete_flag_r;

   // Accepted transfers per kind; result bytes count only while busy
   assign swWrite  = reqOk && req.write && !locked;
   assign swRead   = reqOk && !req.write;
   assign resultOk = locked && resultWr.valid && (resultWr.index <= IDX_LAST);
   assign launchOk = !locked && launchWr;

   // Next byte values: results while busy, software only when idle
   always_comb begin
      for (int i = 0; i < NUM_BYTES; i++) begin
         paramByte_nxt[i] = paramByte_r[i];
      end
      if (resultOk) begin
         // Software writes are dropped while busy and reported as refused
         paramByte_nxt[resultWr.index] = resultWr.value;
      end else if (swWrite) begin
         for (int k = 0; k < 4; k++) begin
            if (3'(k) < sizeBytes(req.size)) begin
               // Lowest byte number takes the top used lane
               paramByte_nxt[req.index + 4'(k)] =
                  req.wdata[laneBase(req.size, k) +: 8];
            end
         end
      end
   end

   // Byte file registers; fields may be loaded in any order
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < NUM_BYTES; i++) begin
            paramByte_r[i] <= BYTE_RESET;
         end
      end else begin
         for (int i = 0; i < NUM_BYTES; i++) begin
            paramByte_r[i] <= paramByte_nxt[i];
         end
      end
   end

   // Read lanes: big-endian, right-justified, upper lanes zero
   always_comb begin
      rdata_nxt = rdata_r;
      if (swRead) begin
         rdata_nxt = 32'h0000_0000;
         for (int k = 0; k < 4; k++) begin
            if (3'(k) < sizeBytes(req.size)) begin
               rdata_nxt[laneBase(req.size, k) +: 8] =
                  paramByte_r[req.index + 4'(k)];
            end
         end
      end
   end

   // Read data holds until the next read, so it may be sampled late
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Read valid pulse; reads are allowed even while a command runs
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= swRead;
      end
   end

   // Refusals: misaligned, out of range, or a write while locked
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reqErr_r <= 1'b0;
      end else begin
         reqErr_r <= req.valid && (!accessOk(req) || (req.write && locked));
      end
   end

   // Complete flag: launch clears it, controller done sets it again
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         command_complete_flag_r <= 1'b1;
      end else if (locked) begin
         if (cmdDone) begin
            command_complete_flag_r <= 1'b1;
         end
      end else if (launchWr) begin
         command_complete_flag_r <= 1'b0;
      end
   end

   // Launch pulse; a launch while busy is dropped, not queued
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cmdStart_r <= 1'b0;
      end else begin
         cmdStart_r <= launchOk;
      end
   end

   // Snapshot at launch; a write in the same cycle misses the snapshot
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cmd_r <= '0;
      end else if (launchOk) begin
         cmd_r.opcode  <= paramByte_r[IDX_OPCODE];
         cmd_r.address <= {paramByte_r[IDX_ADDR_HI],
                           paramByte_r[IDX_ADDR_MD],
                           paramByte_r[IDX_ADDR_LO]};
         // Data byte zero lands in the top lane
         cmd_r.data    <= {paramByte_r[IDX_DATA0],
                           paramByte_r[IDX_DATA0 + 4'h1],
                           paramByte_r[IDX_DATA0 + 4'h2],
                           paramByte_r[IDX_DATA0 + 4'h3],
                           paramByte_r[IDX_DATA0 + 4'h4],
                           paramByte_r[IDX_DATA0 + 4'h5],
                           paramByte_r[IDX_DATA0 + 4'h6],
                           paramByte_r[IDX_DATA0 + 4'h7]};
      end
   end

endmodule // command_parameter_bytes

// File: cmd_param_assertions.sv
// Checker for the command parameter byte file ports
module cmd_param_checker
   import cmd_param_pkg::*;
(
   input wire logic        ref_clk,   // Clock
   input wire logic        resetn,    // Reset
   input wire access_req_t req,       // Access
   input wire logic        launchWr,  // Launch
   input wire logic        cmdDone,   // Done
   input wire logic [31:0] rdata_r,   // Data
   input wire logic        rvalid_r,  // Valid
   input wire logic        reqErr_r,  // Refused
   input wire logic        command_complete_flag_r, // Idle
   input wire logic        cmdStart_r, // Start
   input wire command_t    cmd_r      // Snapshot
);
   logic idle;
   assign idle = command_complete_flag_r;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Legal byte read and launch while idle
   sequence byteRd;
      req.valid && !req.write && req.size == SIZE_BYTE && req.index < 12;
   endsequence
   sequence goCmd;
      launchWr && idle;
   endsequence
   a_read_lanes: assert property (
      byteRd |=> rvalid_r && rdata_r[31:8] == 0)
      else $error("byte read bad");
   a_launch_go: assert property (goCmd |=> cmdStart_r && !idle)
      else $error("launch bad");
   // Snapshot only moves on a launch
   a_snap_hold: assert property (!cmdStart_r |-> $stable(cmd_r))
      else $error("snapshot moved");
   a_lock_err: assert property (
      req.valid && req.write && !idle |=> reqErr_r)
      else $error("busy write taken");
   a_busy_hold: assert property (!idle && !cmdDone |=> !idle)
      else $error("flag rose early");
   a_done_idle: assert property (!idle && cmdDone |=> idle)
      else $error("flag stuck");
   a_half_odd: assert property (
      req.valid && req.size == SIZE_HALF && req.index[0] |=> reqErr_r)
      else $error("odd half taken");
   a_word_align: assert property (
      req.valid && req.size == SIZE_WORD && req.index[1:0] != 0
      |=> reqErr_r)
      else $error("word misalign taken");
endmodule // cmd_param_checker

bind command_parameter_bytes cmd_param_checker u_chk (.*);

// File: command_parameter_bytes_test.sv
// Self-checking bench for the command parameter byte file
module command_parameter_bytes_test
   import cmd_param_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 0, resetn = 0, launchWr = 0, cmdDone = 0;
   access_req_t req = '0;
   result_wr_t  resultWr = '0;
   logic [31:0] rdata_r;
   logic        rvalid_r, reqErr_r, command_complete_flag_r, cmdStart_r;
   command_t    cmd_r;
   int          num_errors = 0, total_checks = 0;
   // 50 MHz clock
   always #10 ref_clk = ~ref_clk;
   command_parameter_bytes dut (.*);
   task chk(string n, logic [95:0] e, g);
      total_checks++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask
   task test_done;
      if (num_errors == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Answer is settled just after the edge that takes the access
   task acc(logic w, access_size_t s, logic [3:0] i, logic [31:0] d);
      @(posedge ref_clk) req <= '{1'b1, w, s, i, d};
      @(posedge ref_clk) req.valid <= 1'b0;
      #1;
   endtask
   // Fields loaded out of order with mixed sizes
   task load_fields;
      acc(1, SIZE_WORD, 4'h8, 32'h5566_7788);
      acc(1, SIZE_HALF, 4'h4, 32'h0000_1122);
      acc(1, SIZE_HALF, 4'h6, 32'h0000_3344);
      acc(1, SIZE_WORD, 4'h0, 32'hA512_3456);
      acc(0, SIZE_HALF, 4'h6, 0);
      chk("half", 32'h0000_3344, rdata_r);
      acc(0, SIZE_BYTE, 4'hB, 0);
      chk("byte11", 32'h0000_0088, rdata_r);
      chk("rvalid", 1'h1, rvalid_r);
      acc(0, SIZE_WORD, 4'h4, 0);
      chk("word", 32'h1122_3344, rdata_r);
   endtask
   task refused;
      acc(0, SIZE_HALF, 4'h3, 0);
      chk("oddhalf", 1'h1, reqErr_r);
      acc(0, SIZE_WORD, 4'h2, 0);
      chk("wordalign", 1'h1, reqErr_r);
      acc(0, SIZE_BYTE, 4'hC, 0);
      chk("byte12", 1'h1, reqErr_r);
   endtask
   // Launch, locked write, result write-back, completion
   task run_cmd;
      @(posedge ref_clk) launchWr <= 1'b1;
      @(posedge ref_clk) launchWr <= 1'b0;
      #1 chk("start", 1'h1, cmdStart_r);
      chk("snap", {8'hA5, 24'h12_3456,
         64'h1122_3344_5566_7788}, cmd_r);
      acc(1, SIZE_BYTE, 4'h0, 32'h0000_0011);
      chk("locked", 1'h1, reqErr_r);
      chk("busy", 1'h0, command_complete_flag_r);
      @(posedge ref_clk) resultWr <= '{1'b1, 4'h4, 8'hAA};
      @(posedge ref_clk) resultWr.valid <= 1'b0;
      cmdDone <= 1'b1;
      @(posedge ref_clk) cmdDone <= 1'b0;
      #1 chk("idle", 1'h1, command_complete_flag_r);
      acc(0, SIZE_BYTE, 4'h4, 0);
      chk("result", 32'h0000_00AA, rdata_r);
      acc(0, SIZE_BYTE, 4'h0, 0);
      chk("opcode", 32'h0000_00A5, rdata_r);
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      load_fields();
      refused();
      run_cmd();
      test_done();
   end
endmodule // command_parameter_bytes_test
